// *** pbd_params.svh ***
`ifndef PBD_PARAMS_SVH
`define PBD_PARAMS_SVH
// Buffer numbers written to the selector port
`define PBD_SEL_N4_LO   4'h0
`define PBD_SEL_N4_HI   4'h1
`define PBD_SEL_W_MID   4'h2
`define PBD_SEL_W_TOP   4'h3
`define PBD_SEL_W_LO    4'h4
`define PBD_SEL_W_HI    4'h5
`define PBD_SEL_N1_LO   4'h6
`define PBD_SEL_N1_HI   4'h7
`define PBD_SEL_N2_LO   4'h8
`define PBD_SEL_N2_HI   4'h9
`define PBD_SEL_N3_LO   4'ha
`define PBD_SEL_N3_HI   4'hb
`define PBD_SEL_XFER    4'hc
// Widths and reset values
`define PBD_WIDE_W      14
`define PBD_NARROW_W    6
`define PBD_RST_SEL     4'h0
// Counter widths: wide frame 2^15 clocks, narrow period 2^7 clocks
`define PBD_FRAME_W     15
`define PBD_NPER_W      7
`endif

// *** pbd_pkg.sv ***
package pbd_pkg;
  typedef logic [13:0] pbd_wide_t;
  typedef logic [5:0]  pbd_narrow_t;
endpackage : pbd_pkg

// *** pbd_narrow_pwm.sv ***
`timescale 1ns/100ps
`include "pbd_params.svh"
// One 6-bit channel: transfer latch, active copy loaded at period start, and active-low pulse
module pbd_narrow_pwm (
  input  wire logic                mclk_in,
  input  wire logic                rst_n_in,
  input  wire logic                xfer_in,
  input  wire pbd_pkg::pbd_narrow_t stage_in,
  input  wire logic [6:0]          phase_in,
  output logic                     pwm_n_out
);
  pbd_pkg::pbd_narrow_t latch_q;
  pbd_pkg::pbd_narrow_t active_q;

  // Transfer latch holds until overwritten
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) latch_q <= '0;
    else if (xfer_in) latch_q <= stage_in;
  end

  // Value taken only at period start so pulses never tear
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) active_q <= '0;
    else if (phase_in == 7'h7f) active_q <= latch_q;
  end

  // Pulse width k times two clocks, period 2^7 clocks
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) pwm_n_out <= 1'b1;
    else pwm_n_out <= !(phase_in[6:1] < active_q);
  end
endmodule : pbd_narrow_pwm

// *** pbd_core.sv ***
`timescale 1ns/100ps
`include "pbd_params.svh"
module pbd_core #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       sel_wr_in,
  input  wire logic [3:0] buffer_number_port_in,
  input  wire logic       nib_wr_in,
  input  wire logic [3:0] staging_nibble_port_in,
  input  wire logic       pins_enable_in,
  output logic            wide_channel_output_out,
  output logic            narrow_channel_a_output_out,
  output logic            narrow_channel_b_output_out,
  output logic            narrow_channel_c_output_out,
  output logic            narrow_channel_d_output_out,
  output logic [4:0]      pin_out,
  output logic [4:0]      pin_oe_n_out
);
  logic [3:0]           sel_q;
  pbd_pkg::pbd_wide_t   wstage_q;
  pbd_pkg::pbd_wide_t   wlatch_q;
  pbd_pkg::pbd_wide_t   wactive_q;
  pbd_pkg::pbd_narrow_t nstage_q [4];
  logic                 xfer_q;
  logic [14:0]          frame_q;
  logic [14:0]          frame_d;
  logic                 wide_n_q;
  logic [3:0]           narrow_n;
  logic [4:0]           pwm_n;
  logic                 extra_hit;
  logic                 pins_en_q;

  // Buffer map seen by the core:
  //   0,1 narrow d low/high pair
  //   2,3 wide bits 9..6 and 13..10
  //   4,5 wide bits 3..0 and 5..4
  //   6,7 narrow a; 8,9 narrow b; a,b narrow c
  //   c   transfer all staging to the latches
  //   d..f nothing at all
  // High-pair buffers keep only the low two bits of the nibble.
  // Staging never reaches a pin directly: latches and period- or frame-aligned
  // active copies sit between, so a half-loaded value is never seen.

  // Selector; writing the transfer code raises a one-cycle transfer
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sel_q  <= `PBD_RST_SEL;
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= sel_wr_in && (buffer_number_port_in == `PBD_SEL_XFER);
      if (sel_wr_in) sel_q <= buffer_number_port_in;
    end
  end

  // Wide staging buffer, one nibble (or pair) per buffer number
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) wstage_q <= '0;
    else if (nib_wr_in) begin
      case (sel_q)
        `PBD_SEL_W_MID: wstage_q[9:6]   <= staging_nibble_port_in;
        `PBD_SEL_W_TOP: wstage_q[13:10] <= staging_nibble_port_in;
        `PBD_SEL_W_LO:  wstage_q[3:0]   <= staging_nibble_port_in;
        `PBD_SEL_W_HI:  wstage_q[5:4]   <= staging_nibble_port_in[1:0];
        default: ;
      endcase
    end
  end

  // Channel a staging: buffers 6 and 7
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      nstage_q[0] <= '0;
    end else if (nib_wr_in && (sel_q == `PBD_SEL_N1_LO)) begin
      nstage_q[0][3:0] <= staging_nibble_port_in;
    end else if (nib_wr_in && (sel_q == `PBD_SEL_N1_HI)) begin
      nstage_q[0][5:4] <= staging_nibble_port_in[1:0];
    end
  end

  // Channel b staging: buffers 8 and 9
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      nstage_q[1] <= '0;
    end else if (nib_wr_in && (sel_q == `PBD_SEL_N2_LO)) begin
      nstage_q[1][3:0] <= staging_nibble_port_in;
    end else if (nib_wr_in && (sel_q == `PBD_SEL_N2_HI)) begin
      nstage_q[1][5:4] <= staging_nibble_port_in[1:0];
    end
  end

  // Channel c staging: buffers a and b
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      nstage_q[2] <= '0;
    end else if (nib_wr_in && (sel_q == `PBD_SEL_N3_LO)) begin
      nstage_q[2][3:0] <= staging_nibble_port_in;
    end else if (nib_wr_in && (sel_q == `PBD_SEL_N3_HI)) begin
      nstage_q[2][5:4] <= staging_nibble_port_in[1:0];
    end
  end

  // Channel d staging: buffers 0 and 1, the reset value of the selector
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      nstage_q[3] <= '0;
    end else if (nib_wr_in && (sel_q == `PBD_SEL_N4_LO)) begin
      nstage_q[3][3:0] <= staging_nibble_port_in;
    end else if (nib_wr_in && (sel_q == `PBD_SEL_N4_HI)) begin
      nstage_q[3][5:4] <= staging_nibble_port_in[1:0];
    end
  end

  // Frame counter wraps on its own, so no terminal compare is needed
  assign frame_d = frame_q + 15'h0001;

  // Free-running frame counter; low 7 bits are the narrow phase
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) frame_q <= '0;
    else frame_q <= frame_d;
  end

  // Wide latch and frame-aligned active copy
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wlatch_q  <= '0;
      wactive_q <= '0;
    end else begin
      if (xfer_q) wlatch_q <= wstage_q;
      if (frame_q == 15'h7fff) wactive_q <= wlatch_q;
    end
  end

  // Lowest set bit of the sub-period index picks the data bit that grants
  // the extra unit; sub-period 0 never gets one, so extras stay spread
  always_comb begin
    extra_hit = 1'b0;
    casez (frame_q[14:9])
      6'b?????1: extra_hit = wactive_q[5]; // Odd sub-periods
      6'b????10: extra_hit = wactive_q[4];
      6'b???100: extra_hit = wactive_q[3];
      6'b??1000: extra_hit = wactive_q[2];
      6'b?10000: extra_hit = wactive_q[1];
      6'b100000: extra_hit = wactive_q[0]; // Middle of the frame only
      default:   extra_hit = 1'b0;         // Sub-period 0
    endcase
  end

  // Wide pulse: n*2 clocks per 512-clock sub-period, plus one 2-clock extra
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) wide_n_q <= 1'b1;
    else wide_n_q <= !(({1'b0, frame_q[8:1]} < ({1'b0, wactive_q[13:6]} +
                        {8'h00, extra_hit})));
  end

  // Four narrow channels share one module
  for (genvar g = 0; g < 4; g++) begin : g_narrow
    pbd_narrow_pwm u_ch (
      .mclk_in   (mclk_in),
      .rst_n_in  (rst_n_in),
      .xfer_in   (xfer_q),
      .stage_in  (nstage_q[g]),
      .phase_in  (frame_q[6:0]),
      .pwm_n_out (narrow_n[g])
    );
  end

  // One vector for the pins: bit 0 wide, bits 1..4 narrow a..d
  assign pwm_n = {narrow_n, wide_n_q};

  // Pin enable latched so pins stay high-impedance until enabled
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) pins_en_q <= 1'b0;
    else pins_en_q <= pins_enable_in;
  end

  // Registered outputs; open drain only pulls low
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wide_channel_output_out     <= 1'b1;
      narrow_channel_a_output_out <= 1'b1;
      narrow_channel_b_output_out <= 1'b1;
      narrow_channel_c_output_out <= 1'b1;
      narrow_channel_d_output_out <= 1'b1;
      pin_out                     <= 5'h1f;
      pin_oe_n_out                <= 5'h1f;
    end else begin
      wide_channel_output_out     <= pwm_n[0];
      narrow_channel_a_output_out <= pwm_n[1];
      narrow_channel_b_output_out <= pwm_n[2];
      narrow_channel_c_output_out <= pwm_n[3];
      narrow_channel_d_output_out <= pwm_n[4];
      pin_out                     <= pwm_n;
      // Open drain releases the pin rather than driving it high
      pin_oe_n_out[0]             <= !pins_en_q || (OPEN_DRAIN && pwm_n[0]);
      pin_oe_n_out[1]             <= !pins_en_q || (OPEN_DRAIN && pwm_n[1]);
      pin_oe_n_out[2]             <= !pins_en_q || (OPEN_DRAIN && pwm_n[2]);
      pin_oe_n_out[3]             <= !pins_en_q || (OPEN_DRAIN && pwm_n[3]);
      pin_oe_n_out[4]             <= !pins_en_q || (OPEN_DRAIN && pwm_n[4]);
    end
  end
endmodule : pbd_core

// *** pbd_lpf.sv ***
`timescale 1ns/100ps
// Box low-pass filter: low cycles of the line per W-cycle window
module pbd_lpf #(
  parameter int W = 128
) (
  input  wire logic   clk_in,
  input  wire logic   pin_in,
  input  wire logic   oe_n_in,
  output logic [10:0] avg_out
);
  logic line_q = 1'b1;
  int   cnt_q  = 0;
  int   acc_q  = 0;
  // Released line has no pull, so it wanders
  always_ff @(posedge clk_in) line_q <= oe_n_in ? ~line_q : pin_in;
  // Any window alignment gives the same sum on a periodic wave
  always_ff @(posedge clk_in) begin
    cnt_q <= (cnt_q == W - 1) ? 0 : cnt_q + 1;
    acc_q <= (cnt_q == W - 1) ? int'(!line_q) : acc_q + int'(!line_q);
    if (cnt_q == W - 1) avg_out <= 11'(acc_q);
  end
endmodule : pbd_lpf

// *** pbd_core_chk.sv ***
`timescale 1ns/100ps
// Pulse shape and idle checks
module pbd_core_chk (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       sel_wr_in,
  input wire logic [3:0] buffer_number_port_in,
  input wire logic       pins_enable_in,
  input wire logic       wide_channel_output_out,
  input wire logic       narrow_channel_a_output_out,
  input wire logic [4:0] pin_oe_n_out
);
  wire        wd = wide_channel_output_out;
  wire        na = narrow_channel_a_output_out;
  logic       seen_q, nf_q, wf_q;
  logic [6:0] nc_q;
  logic [8:0] wc_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Transfer seen since reset
  always_ff @(posedge mclk_in)
    seen_q <= rst_n_in && (seen_q || (sel_wr_in && buffer_number_port_in == 4'hc));
  // Cycles since last falling edge
  always_ff @(posedge mclk_in) begin
    nf_q <= rst_n_in && (nf_q || $fell(na));
    wf_q <= rst_n_in && (wf_q || $fell(wd));
    nc_q <= $fell(na) ? 7'h01 : nc_q + 7'h01;
    wc_q <= $fell(wd) ? 9'h001 : wc_q + 9'h001;
  end
  out_rst_a: assert property (disable iff (1'b0) !rst_n_in |=> wd && na && &pin_oe_n_out)
    else $error("outputs not idle");
  pin_hiz_a: assert property (!pins_enable_in [*3] |-> &pin_oe_n_out)
    else $error("pin driven");
  no_xfer_a: assert property (!seen_q |-> wd && na)
    else $error("pulse before transfer");
  nar_low_a: assert property ($fell(na) |=> !na)
    else $error("narrow pulse short");
  nar_high_a: assert property ($rose(na) |=> na)
    else $error("narrow gap short");
  nar_per_a: assert property ($fell(na) && nf_q |-> nc_q == 7'h00)
    else $error("narrow period");
  wid_low_a: assert property ($fell(wd) |=> !wd)
    else $error("wide pulse short");
  wid_sub_a: assert property ($fell(wd) && wf_q |-> wc_q == 9'h000)
    else $error("wide sub-period");
  cover property ($fell(wd) && wf_q);
  cover property ($fell(na) && nf_q);
  cover property (sel_wr_in && buffer_number_port_in == 4'hd);
endmodule : pbd_core_chk
bind pbd_core pbd_core_chk u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .sel_wr_in(sel_wr_in), .buffer_number_port_in(buffer_number_port_in),
  .pins_enable_in(pins_enable_in), .wide_channel_output_out(wide_channel_output_out),
  .narrow_channel_a_output_out(narrow_channel_a_output_out), .pin_oe_n_out(pin_oe_n_out));

// *** test_pbd_core.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_pbd_core;
  logic        mclk = 1'b0, rst_n = 1'b0, sel_wr = 1'b0, nib_wr = 1'b0, pins_en = 1'b0;
  logic [3:0]  num = 4'h0, nib = 4'h0;
  logic [4:0]  outs, pin, oe_n;
  logic [10:0] avg [5];
  logic [10:0] want [5] = '{11'h0d6, 11'h02a, 11'h034, 11'h046, 11'h07e};
  logic [7:0]  ld [12] = '{8'h25, 8'h33, 8'h40, 8'h5e, 8'h65, 8'h71,
                           8'h8a, 8'h9d, 8'ha3, 8'hb2, 8'h0f, 8'h13};
  int          n_fail = 0, checks = 0;
  pbd_core u_dut (.mclk_in(mclk), .rst_n_in(rst_n), .sel_wr_in(sel_wr),
    .buffer_number_port_in(num), .nib_wr_in(nib_wr), .staging_nibble_port_in(nib),
    .pins_enable_in(pins_en), .wide_channel_output_out(outs[0]),
    .narrow_channel_a_output_out(outs[1]), .narrow_channel_b_output_out(outs[2]),
    .narrow_channel_c_output_out(outs[3]), .narrow_channel_d_output_out(outs[4]),
    .pin_out(pin), .pin_oe_n_out(oe_n));
  // Wide filter spans two sub-periods so odd extras average out
  for (genvar i = 0; i < 5; i++) begin : g_lpf
    pbd_lpf #(.W(i == 0 ? 1024 : 128)) u_lpf (.clk_in(mclk), .pin_in(pin[i]),
      .oe_n_in(oe_n[i]), .avg_out(avg[i]));
  end
  initial forever #2 mclk = ~mclk;
  // Wide data may wait a whole frame
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
  task automatic wr(input logic [3:0] s, input logic [3:0] d);
    @(negedge mclk);
    sel_wr = 1'b1;
    num = s;
    @(negedge mclk);
    sel_wr = 1'b0;
    nib_wr = 1'b1;
    nib = d;
    @(negedge mclk);
    nib_wr = 1'b0;
  endtask : wr
  task automatic t_reset();
    `CHK(outs, 5'h1f)
    `CHK(oe_n, 5'h1f)
  endtask : t_reset
  // Hi bits of e are ignored on a hi-pair buffer
  task automatic t_load();
    for (int i = 0; i < 12; i++) wr(ld[i][7:4], ld[i][3:0]);
    wr(4'hc, 4'h7);
    `CHK(oe_n, 5'h1f)
    pins_en = 1'b1;
    repeat (36000) @(negedge mclk);
    for (int i = 0; i < 5; i++) `CHK(avg[i], want[i])
    `CHK(oe_n, 5'h00)
    `CHK(pin, outs)
  endtask : t_load
  task automatic t_hold();
    wr(4'h6, 4'h1);
    wr(4'h7, 4'h0);
    wr(4'hd, 4'h9);
    repeat (400) @(negedge mclk);
    `CHK(avg[1], 11'h02a)
    wr(4'hc, 4'h0);
    repeat (500) @(negedge mclk);
    `CHK(avg[1], 11'h002)
    `CHK(avg[4], 11'h07e)
  endtask : t_hold
  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    t_reset();
    t_load();
    t_hold();
    stop_test();
  end
endmodule : test_pbd_core
